// [scramble_select_addr_mux.sv]
`timescale 1ns/1ns
`include "scramble_select_defs.svh"
// Functional notes
// - Legacy and new-chipset maps in shared mode
// - Legacy 0-3 column and row low pins
// - Legacy 1-3 upper pins 9 to 11
// - Legacy 4-7 column and row low pins
// - Legacy 4-7 upper pins 9 to 11
// - Legacy 8-11 column and row low pins
// - Legacy 8-11 pin 8 and upper pins
// - Legacy 12-15 column and row low pins
// - Legacy 12-15 upper pins 9 to 11
// - New setting 0 serves symmetric DRAM
// - New settings 4, 6 serve asymmetric DRAM
// - New map 64-bit column pins
// - New map 64-bit row pins
// - New map 32-bit column pins
// - New map 32-bit row pins

module scramble_select_addr_mux (
    // Clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_sys_rst,
    // Configuration
    input  wire logic                 i_shared_mode,
    input  wire logic                 i_table_b,
    input  wire logic                 i_bus_64,
    input  wire logic [`SEL_W-1:0]    i_scramble_select,
    // Access sequencer
    input  wire scramble_select_pkg::mem_addr_t i_mem_addr,
    input  wire logic                 i_row_strobe,
    input  wire logic                 i_col_strobe,
    // DRAM address pins
    output scramble_select_pkg::mux_addr_t      o_dram_mux_address_q,
    output scramble_select_pkg::phase_t         o_phase_q,
    output logic                      o_select_legal_q
);

    scramble_select_pkg::map_vec_t map_sel;
    scramble_select_pkg::mux_addr_t picked;
    logic                 sel_legal;
    logic                 col_now;
    logic                 row_now;
    logic                 leg_col;
    logic                 leg_row;
    logic                 nb_col;
    logic                 nb_row;

    // Select the table entry for one access phase
    function automatic scramble_select_pkg::map_vec_t map_lookup(
        input logic             tb,
        input logic             w64,
        input logic [`SEL_W-1:0] sel,
        input logic             col
    );
        map_lookup = `NB_UNUSED;
        if (!tb) begin
            unique case (sel)
                4'h0: map_lookup = col ? `LA_C0  : `LA_R0;
                4'h1: map_lookup = col ? `LA_C1  : `LA_R1;
                4'h2: map_lookup = col ? `LA_C2  : `LA_R2;
                4'h3: map_lookup = col ? `LA_C3  : `LA_R3;
                4'h4: map_lookup = col ? `LA_C4  : `LA_R4;
                4'h5: map_lookup = col ? `LA_C5  : `LA_R5;
                4'h6: map_lookup = col ? `LA_C6  : `LA_R6;
                4'h7: map_lookup = col ? `LA_C7  : `LA_R7;
                4'h8: map_lookup = col ? `LA_C8  : `LA_R8;
                4'h9: map_lookup = col ? `LA_C9  : `LA_R9;
                4'hA: map_lookup = col ? `LA_C10 : `LA_R10;
                4'hB: map_lookup = col ? `LA_C11 : `LA_R11;
                4'hC: map_lookup = col ? `LA_C12 : `LA_R12;
                4'hD: map_lookup = col ? `LA_C13 : `LA_R13;
                4'hE: map_lookup = col ? `LA_C14 : `LA_R14;
                4'hF: map_lookup = col ? `LA_C15 : `LA_R15;
            endcase
        end else if (w64) begin
            case (sel)
                `SEL_B_SYM:    map_lookup = col ? `NB_C64_S0 : `NB_R64_S0;
                `SEL_B_ASYM_A: map_lookup = col ? `NB_C64_S4 : `NB_R64_S4;
                `SEL_B_ASYM_B: map_lookup = col ? `NB_C64_S6 : `NB_R64_S6;
                default:       map_lookup = `NB_UNUSED;
            endcase
        end else begin
            case (sel)
                `SEL_B_SYM:    map_lookup = col ? `NB_C32_S0 : `NB_R32_S0;
                `SEL_B_ASYM_A: map_lookup = col ? `NB_C32_S4 : `NB_R32_S4;
                `SEL_B_ASYM_B: map_lookup = col ? `NB_C32_S6 : `NB_R32_S6;
                default:       map_lookup = `NB_UNUSED;
            endcase
        end
    endfunction

    assign col_now = i_col_strobe;
    assign row_now = i_row_strobe && !i_col_strobe;

    // Only settings 0, 4 and 6 exist in the new map
    assign sel_legal = !i_table_b
                     || (i_scramble_select == `SEL_B_SYM)
                     || (i_scramble_select == `SEL_B_ASYM_A)
                     || (i_scramble_select == `SEL_B_ASYM_B);

    // Map chosen live from table, width and setting
    always_comb begin
        map_sel = map_lookup(i_table_b, i_bus_64, i_scramble_select,
                             col_now);
    end

    scramble_select_bit_pick u_pick (
        .i_map      (map_sel),
        .i_mem_addr (i_mem_addr),
        .o_bits     (picked)
    );

    // Helper terms for the checks below
    assign leg_col = i_shared_mode && !i_table_b && col_now;
    assign leg_row = i_shared_mode && !i_table_b && row_now;
    assign nb_col  = i_shared_mode && i_table_b && col_now;
    assign nb_row  = i_shared_mode && i_table_b && row_now;

    // Phase tracks the strobes, address held between phases
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || !i_shared_mode) begin
            o_phase_q <= scramble_select_pkg::PH_IDLE;
        end else begin
            unique case ({col_now, row_now})
                2'b10:   o_phase_q <= scramble_select_pkg::PH_COL;
                2'b01:   o_phase_q <= scramble_select_pkg::PH_ROW;
                2'b00:   o_phase_q <= scramble_select_pkg::PH_IDLE;
            endcase
        end
    end

    // Registered pins; a new setting shows on the next access
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || !i_shared_mode) begin
            o_dram_mux_address_q <= `MUX_ZERO;
        end else if (col_now || row_now) begin
            o_dram_mux_address_q <= picked;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_select_legal_q <= 1'b1;
        end else begin
            o_select_legal_q <= sel_legal;
        end
    end

    // Outside shared mode the pins stay low and idle
    no_shared_low_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && !$past(i_shared_mode)) |->
        (o_dram_mux_address_q == `MUX_ZERO
         && o_phase_q == scramble_select_pkg::PH_IDLE))
        else $error("pins not idle outside shared mode");

    leg03_col_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(leg_col)
         && $past(i_scramble_select) <= 4'h3) |->
        (o_dram_mux_address_q[1:0] == {$past(i_mem_addr[11]),
                                       $past(i_mem_addr[4])}
         && o_dram_mux_address_q[8] == $past(i_mem_addr[10])))
        else $error("legacy 0-3 column pins wrong");

    leg0_row_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(leg_row)
         && $past(i_scramble_select) == 4'h0) |->
        o_dram_mux_address_q[8:0] == $past(i_mem_addr[20:12]))
        else $error("legacy 0 row pins wrong");

    leg3_upper_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(leg_row)
         && $past(i_scramble_select) == 4'h3) |->
        o_dram_mux_address_q[11:9] == {$past(i_mem_addr[25]),
                                       $past(i_mem_addr[23]),
                                       $past(i_mem_addr[21])})
        else $error("legacy 3 row upper pins wrong");

    leg47_row_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(leg_row)
         && $past(i_scramble_select[3:2]) == 2'b01) |->
        (o_dram_mux_address_q[8:1] == $past(i_mem_addr[20:13])
         && o_dram_mux_address_q[0] == ($past(i_scramble_select[1])
             ? $past(i_mem_addr[22]) : $past(i_mem_addr[12]))))
         else $error("legacy 4-7 row pins wrong");

    leg7_upper_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(leg_row)
         && $past(i_scramble_select) == 4'h7) |->
        o_dram_mux_address_q[11:9] == {$past(i_mem_addr[24]),
                                       $past(i_mem_addr[23]),
                                       $past(i_mem_addr[21])})
        else $error("legacy 7 row upper pins wrong");

    leg811_col_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(leg_col)
         && $past(i_scramble_select[3:2]) == 2'b10) |->
        o_dram_mux_address_q[2:0] == {$past(i_mem_addr[3]),
                                      $past(i_mem_addr[2]),
                                      $past(i_mem_addr[4])})
        else $error("legacy 8-11 column pins wrong");

    leg8_row_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(leg_row)
         && $past(i_scramble_select) == 4'h8) |->
        o_dram_mux_address_q[8] == $past(i_mem_addr[11]))
        else $error("legacy 8 row pin 8 wrong");

    leg1215_row_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(leg_row)
         && $past(i_scramble_select[3:2]) == 2'b11) |->
        o_dram_mux_address_q[8:1] == $past(i_mem_addr[20:13]))
        else $error("legacy 12-15 row pins wrong");

    leg15_upper_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(leg_row)
         && $past(i_scramble_select) == 4'hF) |->
        o_dram_mux_address_q[11:9] == {$past(i_mem_addr[12]),
                                       $past(i_mem_addr[23]),
                                       $past(i_mem_addr[21])})
        else $error("legacy 15 row upper pins wrong");

    nb_legal_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(i_table_b)) |->
        o_select_legal_q == ($past(i_scramble_select) inside
            {`SEL_B_SYM, `SEL_B_ASYM_A, `SEL_B_ASYM_B}))
        else $error("new map setting legality wrong");

    nb_asym_b_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(nb_row) && $past(i_bus_64)
         && $past(i_scramble_select) == `SEL_B_ASYM_B) |->
        o_dram_mux_address_q[11:8] == {$past(i_mem_addr[22]),
                                       $past(i_mem_addr[21]),
                                       $past(i_mem_addr[11]),
                                       $past(i_mem_addr[20])})
        else $error("new map setting 6 row pins wrong");

    nb64_col_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(nb_col) && $past(i_bus_64)
         && $past(i_scramble_select) == `SEL_B_SYM) |->
        (o_dram_mux_address_q[7:0] == $past(i_mem_addr[10:3])
         && o_dram_mux_address_q[9] == $past(i_mem_addr[21])))
        else $error("new map 64-bit column pins wrong");

    nb64_row_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(nb_row) && $past(i_bus_64)
         && $past(i_scramble_select) == `SEL_B_SYM) |->
        o_dram_mux_address_q[8:0] == $past(i_mem_addr[20:12]))
        else $error("new map 64-bit row pins wrong");

    nb32_col_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(nb_col) && !$past(i_bus_64)
         && $past(i_scramble_select) == `SEL_B_ASYM_A) |->
        (o_dram_mux_address_q[7] == $past(i_mem_addr[4])
         && o_dram_mux_address_q[9] == $past(i_mem_addr[22])))
        else $error("new map 32-bit column pins wrong");

    nb32_row_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(nb_row) && !$past(i_bus_64)
         && $past(i_scramble_select) == `SEL_B_ASYM_B) |->
        o_dram_mux_address_q[11:8] == {$past(i_mem_addr[21]),
                                       $past(i_mem_addr[20]),
                                       $past(i_mem_addr[10]),
                                       $past(i_mem_addr[11])})
        else $error("new map 32-bit row pins wrong");

    unused_low_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(leg_col)
         && $past(i_scramble_select) == 4'h0) |->
        o_dram_mux_address_q[11:9] == 3'h0)
        else $error("unused pins not low");

    hold_idle_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && $past(i_shared_mode)
         && !$past(i_row_strobe) && !$past(i_col_strobe)) |->
        (o_phase_q == scramble_select_pkg::PH_IDLE
         && $stable(o_dram_mux_address_q)))
        else $error("pins moved with no strobe");

    col_wins_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_shared_mode && i_col_strobe) |=>
        o_phase_q == scramble_select_pkg::PH_COL)
        else $error("column phase not shown");

endmodule

// [scramble_select_defs.svh]
`ifndef SCRAMBLE_SELECT_DEFS_SVH
`define SCRAMBLE_SELECT_DEFS_SVH

// Widths
`define ADDR_W       27
`define MUX_W        12
`define IDX_W        8
`define MAP_W        96
`define SEL_W        4

// Entry code for an unused pin and the first index past the address
`define IDX_NA       8'hFF
`define ADDR_LIMIT   8'h1B
`define MUX_ZERO     12'h000

// New-chipset map settings
`define SEL_B_SYM    4'h0
`define SEL_B_ASYM_A 4'h4
`define SEL_B_ASYM_B 4'h6

// Legacy map, 8-bit bit index per pin, pin 11 in the top byte
`define LA_C0  96'hFF_FF_FF_0A_09_08_07_06_05_03_0B_04
`define LA_R0  96'hFF_FF_FF_14_13_12_11_10_0F_0E_0D_0C
`define LA_C1  96'hFF_FF_0C_0A_09_08_07_06_05_03_0B_04
`define LA_R1  96'hFF_FF_15_14_13_12_11_10_0F_0E_0D_16
`define LA_C2  96'hFF_0D_0C_0A_09_08_07_06_05_03_0B_04
`define LA_R2  96'hFF_17_15_14_13_12_11_10_0F_0E_18_16
`define LA_C3  96'h0E_0D_0C_0A_09_08_07_06_05_03_0B_04
`define LA_R3  96'h19_17_15_14_13_12_11_10_0F_10_18_16
`define LA_C4  96'hFF_FF_FF_0A_09_08_07_06_05_03_0B_04
`define LA_R4  96'hFF_FF_15_14_13_12_11_10_0F_0E_0D_0C
`define LA_C5  96'hFF_FF_FF_0A_09_08_07_06_05_03_0B_04
`define LA_R5  96'hFF_16_15_14_13_12_11_10_0F_0E_0D_0C
`define LA_C6  96'hFF_FF_0C_0A_09_08_07_06_05_03_0B_04
`define LA_R6  96'hFF_17_15_14_13_12_11_10_0F_0E_0D_16
`define LA_C7  96'hFF_FF_0C_0A_09_08_07_06_05_03_0B_04
`define LA_R7  96'h18_17_15_14_13_12_11_10_0F_0E_0D_16
`define LA_C8  96'hFF_FF_FF_0A_09_08_07_06_05_03_02_04
`define LA_R8  96'hFF_FF_FF_0B_13_12_11_10_0F_0E_0D_0C
`define LA_C9  96'hFF_FF_0B_0A_09_08_07_06_05_03_02_04
`define LA_R9  96'hFF_FF_15_14_13_12_11_10_0F_0E_0D_0C
`define LA_C10 96'hFF_0C_0B_0A_09_08_07_06_05_03_02_04
`define LA_R10 96'hFF_17_15_14_13_12_11_10_0F_0E_0D_16
`define LA_C11 96'h0D_0C_0B_0A_09_08_07_06_05_03_02_04
`define LA_R11 96'h19_17_15_14_13_12_11_10_0F_0E_18_16
`define LA_C12 96'hFF_FF_FF_0A_09_08_07_06_05_03_02_04
`define LA_R12 96'hFF_FF_0B_14_13_12_11_10_0F_0E_0D_0C
`define LA_C13 96'hFF_FF_FF_0A_09_08_07_06_05_03_02_04
`define LA_R13 96'hFF_0B_15_14_13_12_11_10_0F_0E_0D_0C
`define LA_C14 96'hFF_FF_0B_0A_09_08_07_06_05_03_02_04
`define LA_R14 96'hFF_0C_15_14_13_12_11_10_0F_0E_0D_16
`define LA_C15 96'hFF_FF_0B_0A_09_08_07_06_05_03_02_04
`define LA_R15 96'h0C_17_15_14_13_12_11_10_0F_0E_0D_16

// New-chipset map, 64-bit and 32-bit DRAM
`define NB_C64_S0 96'h19_17_15_0B_0A_09_08_07_06_05_04_03
`define NB_R64_S0 96'h1A_18_16_14_13_12_11_10_0F_0E_0D_0C
`define NB_C64_S4 96'h1A_19_17_0B_0A_09_08_07_06_05_04_03
`define NB_R64_S4 96'h18_16_15_14_13_12_11_10_0F_0E_0D_0C
`define NB_C64_S6 96'h1A_19_18_17_0A_09_08_07_06_05_04_03
`define NB_R64_S6 96'h16_15_0B_14_13_12_11_10_0F_0E_0D_0C
`define NB_C32_S0 96'h19_17_15_0A_04_09_08_07_06_05_03_02
`define NB_R32_S0 96'h18_16_14_0B_13_12_11_10_0F_0E_0D_0C
`define NB_C32_S4 96'h19_18_16_0A_04_09_08_07_06_05_03_02
`define NB_R32_S4 96'h17_15_14_0B_13_12_11_10_0F_0E_0D_0C
`define NB_C32_S6 96'h19_18_17_16_04_09_08_07_06_05_03_02
`define NB_R32_S6 96'h15_14_0A_0B_13_12_11_10_0F_0E_0D_0C
`define NB_UNUSED 96'hFF_FF_FF_FF_FF_FF_FF_FF_FF_FF_FF_FF

`endif

// [scramble_select_pkg.sv]
`include "scramble_select_defs.svh"

package scramble_select_pkg;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ROW  = 2'b01,
        PH_COL  = 2'b10
    } phase_t;

    typedef logic [`MAP_W-1:0]  map_vec_t;
    typedef logic [`ADDR_W-1:0] mem_addr_t;
    typedef logic [`MUX_W-1:0]  mux_addr_t;
endpackage

// [scramble_select_bit_pick.sv]
`timescale 1ns/1ns
`include "scramble_select_defs.svh"

module scramble_select_bit_pick (
    // Map and source address
    input  wire scramble_select_pkg::map_vec_t  i_map,
    input  wire scramble_select_pkg::mem_addr_t i_mem_addr,
    // Picked pin values
    output scramble_select_pkg::mux_addr_t      o_bits
);

    // Out-of-range codes give a low pin, so unused pins stay quiet
    function automatic logic pick_bit(
        input logic [`IDX_W-1:0]  idx,
        input scramble_select_pkg::mem_addr_t addr
    );
        pick_bit = (idx < `ADDR_LIMIT) ? addr[idx[4:0]] : 1'b0;
    endfunction

    always_comb begin
        for (int i = 0; i < `MUX_W; i++) begin
            o_bits[i] = pick_bit(i_map[i*`IDX_W +: `IDX_W], i_mem_addr);
        end
    end

endmodule

// [dram_array_model.sv]
`timescale 1ns/1ns
module dram_array_model (
    // Clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_sys_rst,
    // Pins from the scrambler
    input  wire scramble_select_pkg::mux_addr_t i_dram_mux_address,
    input  wire logic [1:0]           i_phase,
    // Last row and column opened
    output scramble_select_pkg::mux_addr_t      o_row_q,
    output scramble_select_pkg::mux_addr_t      o_col_q
);
    // Latch per phase; reset clears both
    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_row_q <= 12'h000;
            o_col_q <= 12'h000;
        end else begin
            if (i_phase === 2'h1) begin
                o_row_q <= i_dram_mux_address;
            end
            if (i_phase === 2'h2) begin
                o_col_q <= i_dram_mux_address;
            end
        end
    end
endmodule

// [scramble_select_addr_mux_bench.sv]
`timescale 1ns/1ns
module scramble_select_addr_mux_bench;
    logic                 i_ref_clk;
    logic                 i_sys_rst;
    logic                 i_shared_mode;
    logic                 i_table_b;
    logic                 i_bus_64;
    logic [3:0]           i_scramble_select;
    scramble_select_pkg::mem_addr_t i_mem_addr;
    logic                 i_row_strobe;
    logic                 i_col_strobe;
    scramble_select_pkg::mux_addr_t o_dram_mux_address_q;
    scramble_select_pkg::phase_t    o_phase_q;
    logic                 o_select_legal_q;
    scramble_select_pkg::mux_addr_t row_seen;
    scramble_select_pkg::mux_addr_t col_seen;
    scramble_select_pkg::mux_addr_t exp_addr_q;
    scramble_select_pkg::mux_addr_t exp_row_q;
    scramble_select_pkg::mux_addr_t exp_col_q;
    logic [1:0]           exp_phase_q;
    logic                 exp_legal_q;
    logic [31:0]          seed;
    int                   fail_count;
    int                   check_count;
    int                   s;
    int                   n;
    int ca64 [9] = '{4, 11, 3, 5, 6, 7, 8, 9, 10};
    int ca32 [9] = '{4, 2, 3, 5, 6, 7, 8, 9, 10};
    int cb32 [8] = '{2, 3, 5, 6, 7, 8, 9, 4};
    // Upper pins of the new map: width, phase, setting, pin 8..11
    int ub [48] = '{11, 21, 23, 25, 11, 23, 25, 26, 23, 24, 25, 26,
                    20, 22, 24, 26, 20, 21, 22, 24, 20, 11, 21, 22,
                    10, 21, 23, 25, 10, 22, 24, 25, 22, 23, 24, 25,
                    11, 20, 22, 24, 11, 20, 21, 23, 11, 10, 20, 21};

    scramble_select_addr_mux u_dut (
        .i_ref_clk            (i_ref_clk),
        .i_sys_rst            (i_sys_rst),
        .i_shared_mode        (i_shared_mode),
        .i_table_b            (i_table_b),
        .i_bus_64             (i_bus_64),
        .i_scramble_select    (i_scramble_select),
        .i_mem_addr           (i_mem_addr),
        .i_row_strobe         (i_row_strobe),
        .i_col_strobe         (i_col_strobe),
        .o_dram_mux_address_q (o_dram_mux_address_q),
        .o_phase_q            (o_phase_q),
        .o_select_legal_q     (o_select_legal_q)
    );

    dram_array_model u_dram (
        .i_ref_clk          (i_ref_clk),
        .i_sys_rst          (i_sys_rst),
        .i_dram_mux_address (o_dram_mux_address_q),
        .i_phase            (o_phase_q),
        .o_row_q            (row_seen),
        .o_col_q            (col_seen)
    );

    initial i_ref_clk = 1'b0;
    always #5 i_ref_clk = ~i_ref_clk;

    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Bit index per pin, -1 where the pin is unused
    function automatic int pick(bit tb, bit w, int sel, bit col, int p);
        int g;
        int k;
        int t;
        g = sel / 4;
        k = sel % 4;
        t = (sel == 0) ? 0 : (sel == 4) ? 1 : 2;
        if (tb) begin
            if (p < 8) return col ? (w ? p + 3 : cb32[p]) : p + 12;
            return ub[(w ? 0 : 24) + (col ? 0 : 12) + t * 4 + p - 8];
        end
        if (col) begin
            if (p < 9) return (g < 2) ? ca64[p] : ca32[p];
            if (g == 0 || g == 2) return (p - 8 <= k) ? 21 - g / 2 + p - 18 : -1;
            return (p == 9 && k >= 2) ? (g == 1 ? 12 : 11) : -1;
        end
        case (p)
            0: return ((g == 0) ? k == 0 : k < 2) ? 12 : 22;
            1: return ((g == 0 && k >= 2) || (g == 2 && k == 3)) ? 24 : 13;
            2: return (g == 0 && k == 3) ? 16 : 14;
            8: return (g == 2 && k == 0) ? 11 : 20;
            9: return (g == 1) ? 21 : (g == 3) ? (k == 0 ? 11 : 21)
                   : (k >= 1 ? 21 : -1);
            10: return (g == 1) ? (k == 1 ? 22 : k >= 2 ? 23 : -1)
                   : (g == 3) ? (k == 1 ? 11 : k == 2 ? 12 : k == 3 ? 23 : -1)
                   : (k >= 2 ? 23 : -1);
            11: return (k != 3) ? -1 : (g == 1) ? 24 : (g == 3) ? 12 : 25;
            default: return p + 12;
        endcase
    endfunction

    function automatic scramble_select_pkg::mux_addr_t mapped(bit col);
        scramble_select_pkg::mux_addr_t v;
        int k;
        for (int p = 0; p < 12; p++) begin
            k = pick(i_table_b, i_bus_64, int'(i_scramble_select), col, p);
            v[p] = (k < 0) ? 1'b0 : i_mem_addr[k];
        end
        return v;
    endfunction

    // Reference model, one cycle behind the inputs like the pins
    always @(posedge i_ref_clk) begin
        if (exp_phase_q == 2'h1) exp_row_q <= exp_addr_q;
        if (exp_phase_q == 2'h2) exp_col_q <= exp_addr_q;
        if (i_sys_rst) begin
            exp_addr_q  <= 12'h000;
            exp_phase_q <= 2'h0;
            exp_legal_q <= 1'b1;
            exp_row_q   <= 12'h000;
            exp_col_q   <= 12'h000;
        end else begin
            exp_legal_q <= !(i_table_b &&
                !(i_scramble_select inside {4'h0, 4'h4, 4'h6}));
            if (!i_shared_mode) begin
                exp_addr_q  <= 12'h000;
                exp_phase_q <= 2'h0;
            end else if (i_col_strobe || i_row_strobe) begin
                exp_phase_q <= i_col_strobe ? 2'h2 : 2'h1;
                exp_addr_q  <= (i_table_b && !(i_scramble_select inside
                    {4'h0, 4'h4, 4'h6})) ? 12'h000 : mapped(i_col_strobe);
            end else begin
                exp_phase_q <= 2'h0;
            end
        end
    end

    task automatic cmp(string what, logic [11:0] exp, logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    always @(negedge i_ref_clk) begin
        cmp("address", exp_addr_q, o_dram_mux_address_q);
        cmp("phase", {10'h000, exp_phase_q}, {10'h000, o_phase_q});
        cmp("legal", {11'h000, exp_legal_q},
            {11'h000, o_select_legal_q});
        cmp("row_latch", exp_row_q, row_seen);
        cmp("col_latch", exp_col_q, col_seen);
    end

    // Row, column, both strobes, then idle
    task automatic access(bit tb, bit w, int sel, bit sh);
        @(posedge i_ref_clk);
        seed = lfsr(seed);
        i_shared_mode     <= sh;
        i_table_b         <= tb;
        i_bus_64          <= w;
        i_scramble_select <= sel[3:0];
        i_mem_addr        <= seed[26:0];
        i_row_strobe      <= 1'b1;
        @(posedge i_ref_clk);
        i_row_strobe <= 1'b0;
        i_col_strobe <= 1'b1;
        @(posedge i_ref_clk);
        seed = lfsr(seed);
        i_mem_addr   <= seed[26:0];
        i_row_strobe <= 1'b1;
        @(posedge i_ref_clk);
        i_row_strobe <= 1'b0;
        i_col_strobe <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        fail_count++;
        test_done;
    end

    initial begin
        fail_count = 0;
        check_count = 0;
        seed = 32'hC9843209;
        i_sys_rst = 1'b1;
        i_shared_mode = 1'b1;
        i_table_b = 1'b0;
        i_bus_64 = 1'b0;
        i_scramble_select = 4'h0;
        i_mem_addr = 27'h0000000;
        i_row_strobe = 1'b0;
        i_col_strobe = 1'b0;
        repeat (16) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        repeat (4) for (s = 0; s < 4; s++) access(0, s[0], s, 1);
        repeat (4) for (s = 0; s < 4; s++) access(0, s[1], s, 1);
        repeat (4) for (s = 4; s < 8; s++) access(0, 1, s, 1);
        repeat (4) for (s = 4; s < 8; s++) access(0, 0, s, 1);
        repeat (4) for (s = 8; s < 12; s++) access(0, 0, s, 1);
        repeat (4) for (s = 8; s < 12; s++) access(0, 1, s, 1);
        repeat (4) for (s = 12; s < 16; s++) access(0, 0, s, 1);
        repeat (4) for (s = 12; s < 16; s++) access(0, 1, s, 1);
        repeat (6) access(1, 1, 0, 1);
        repeat (6) access(1, 1, 4, 1);
        repeat (6) for (s = 0; s < 8; s += 2) access(1, 1, s, 1);
        repeat (6) for (s = 0; s < 8; s += 2) access(1, 1, s, 1);
        repeat (6) for (s = 0; s < 8; s += 2) access(1, 0, s, 1);
        repeat (6) for (s = 0; s < 8; s += 2) access(1, 0, s, 1);
        for (s = 0; s < 16; s++) access(1, s[0], s, 1);
        for (s = 0; s < 16; s++) access(0, 0, s, 0);
        // Second reset in mid-run, straight after a row phase
        @(posedge i_ref_clk);
        i_shared_mode <= 1'b1;
        i_row_strobe <= 1'b1;
        @(posedge i_ref_clk);
        i_sys_rst <= 1'b1;
        i_row_strobe <= 1'b0;
        @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        // Every input but reset changing every cycle, select included
        for (n = 0; n < 400; n++) begin
            @(posedge i_ref_clk);
            seed = lfsr(seed);
            i_table_b <= seed[0];
            i_bus_64 <= seed[1];
            i_scramble_select <= seed[5:2];
            i_row_strobe <= seed[6];
            i_col_strobe <= seed[7] & seed[8];
            i_shared_mode <= seed[0] | seed[9] | seed[10];
            seed = lfsr(seed);
            i_mem_addr <= seed[31:5];
        end
        repeat (3) @(posedge i_ref_clk);
        test_done;
    end
endmodule
